// file: hdl/orient_classifier.sv
`timescale 1ns/10ps
module orient_classifier
  import orient_pkg::*;
#(
  parameter logic [4:0] TRIP_THRESHOLD = TRIP_THRESHOLD_DEFAULT,
  parameter logic [2:0] TRIP_MARGIN    = TRIP_MARGIN_DEFAULT
)(
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     sample_i,
  input  wire logic signed [AXIS_W-1:0] x_i,
  input  wire logic signed [AXIS_W-1:0] y_i,
  input  wire logic signed [AXIS_W-1:0] z_i,
  input  wire logic [1:0]               bf_sel_i,
  input  wire logic [2:0]               zl_sel_i,
  input  wire logic [1:0]               cur_code_i,
  input  wire logic                     cur_face_i,
  orient_if.src                         res
);
  // Landscape entry and exit angles around the threshold
  localparam int THR_DEG   = int'(TRIP_THRESHOLD) * THRESHOLD_DEG_NUM / THRESHOLD_DEG_DEN;
  localparam int MRG_DEG   = MARGIN_DEG[TRIP_MARGIN];
  localparam int ENTER_DEG = (THR_DEG + MRG_DEG > 85) ? 85 : THR_DEG + MRG_DEG;
  localparam int EXIT_DEG  = (THR_DEG > MRG_DEG) ? THR_DEG - MRG_DEG : 0;
  localparam logic [9:0] ENTER_TAN = TAN64_5DEG[ENTER_DEG / 5];
  localparam logic [9:0] EXIT_TAN  = TAN64_5DEG[EXIT_DEG / 5];

  logic [AXIS_W-1:0] ax, ay, az, h;
  logic [23:0]       h64, ax64, zl_lim, bf_lim, land_lim;
  logic              is_lock, is_land, over;
  logic [1:0]        code_reg, code_next;
  logic              face_reg, face_next, lock_reg, lock_next;
  logic              hold_reg, hold_next, valid_reg, valid_next;

  // Tangent compares avoid any divider or arctangent
  always_comb begin
    ax       = x_i[AXIS_W-1] ? AXIS_W'(-x_i) : AXIS_W'(x_i);
    ay       = y_i[AXIS_W-1] ? AXIS_W'(-y_i) : AXIS_W'(y_i);
    az       = z_i[AXIS_W-1] ? AXIS_W'(-z_i) : AXIS_W'(z_i);
    h        = (ax > ay) ? ax : ay;
    h64      = {4'h0, h, 6'h00};
    ax64     = {4'h0, ax, 6'h00};
    zl_lim   = Z_TILT_ANGLE_SEL_TAN[zl_sel_i] * az;
    bf_lim   = BF_TAN[bf_sel_i] * az;
    land_lim = (cur_code_i[1] ? EXIT_TAN : ENTER_TAN) * ay;
    is_lock  = h64 < zl_lim;
    is_land  = cur_code_i[1] ? (ax64 >= land_lim) : (ax64 > land_lim);
    over     = (ax > OVER_G_COUNTS) || (ay > OVER_G_COUNTS) || (az > OVER_G_COUNTS);
    code_next  = code_reg;
    face_next  = face_reg;
    lock_next  = lock_reg;
    hold_next  = hold_reg;
    valid_next = sample_i;
    if (sample_i) begin
      lock_next = is_lock;
      hold_next = over;
      // Between the two regions the facing side is kept
      face_next = cur_face_i;
      if (h64 < bf_lim) begin
        face_next = z_i[AXIS_W-1] ? FACE_FRONT : FACE_BACK;
      end
      code_next = cur_code_i;
      if (!is_lock) begin
        if (is_land) begin
          code_next = x_i[AXIS_W-1] ? LANDSCAPE_LEFT : LANDSCAPE_RIGHT;
        end else begin
          code_next = y_i[AXIS_W-1] ? PORTRAIT_DOWN : PORTRAIT_UP;
        end
      end
    end
  end

  // Candidate registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_reg  <= 2'h0;
      face_reg  <= 1'b0;
      lock_reg  <= 1'b0;
      hold_reg  <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      code_reg  <= code_next;
      face_reg  <= face_next;
      lock_reg  <= lock_next;
      hold_reg  <= hold_next;
      valid_reg <= valid_next;
    end
  end

  assign res.code  = code_reg;
  assign res.face  = face_reg;
  assign res.lock  = lock_reg;
  assign res.hold  = hold_reg;
  assign res.valid = valid_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_OVER_G_HOLD: assert property ((sample_i && over) |=> res.hold && res.valid)
    else $error("over-g sample did not raise hold");
  AST_LOCK_KEEPS_CODE: assert property (
    (sample_i && is_lock) |=> res.lock && res.code == $past(cur_code_i))
    else $error("lockout sample changed orientation code");
endmodule : orient_classifier

// file: hdl/orient_debounce.sv
`timescale 1ns/10ps
module orient_debounce
  import orient_pkg::*;
#(
  parameter int unsigned STEP_BASE_CYCLES = STEP_BASE_CYCLES_DEFAULT
)(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       restart_i,
  input  wire logic       pending_i,
  input  wire logic       dbmode_i,
  input  wire logic [7:0] step_mult_i,
  input  wire logic [7:0] dbval_i,
  output logic            commit_o
);
  localparam int CW = $clog2(STEP_BASE_CYCLES + 1);

  if (STEP_BASE_CYCLES < 1) begin : g_bad_step
    $error("step base must be at least one cycle");
  end

  logic [CW-1:0] base_reg, base_next;
  logic [7:0]    mult_reg, mult_next, cnt_reg, cnt_next;
  logic          step;

  // Prescaler restarts with the counter so a step never straddles a wake change
  always_comb begin
    step      = 1'b0;
    base_next = base_reg + CW'(1);
    mult_next = mult_reg;
    if (base_reg == CW'(STEP_BASE_CYCLES - 1)) begin
      base_next = '0;
      mult_next = mult_reg + 8'h01;
      if (mult_reg >= step_mult_i - 8'h01) begin
        mult_next = 8'h00;
        step      = 1'b1;
      end
    end
    if (restart_i) begin
      base_next = '0;
      mult_next = 8'h00;
    end
  end

  // Debounce counter
  always_comb begin
    commit_o = pending_i && (cnt_reg >= dbval_i);
    cnt_next = cnt_reg;
    if (restart_i || commit_o) begin
      cnt_next = 8'h00;
    end else if (!pending_i && dbmode_i) begin
      cnt_next = 8'h00;
    end else if (step) begin
      if (pending_i) begin
        cnt_next = (cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01;
      end else begin
        cnt_next = (cnt_reg == 8'h00) ? cnt_reg : cnt_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_reg <= '0;
      mult_reg <= 8'h00;
      cnt_reg  <= 8'h00;
    end else begin
      base_reg <= base_next;
      mult_reg <= mult_next;
      cnt_reg  <= cnt_next;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_RESTART_CLEARS: assert property (restart_i |=> cnt_reg == 8'h00)
    else $error("wake change did not clear debounce counter");
  AST_CLEAR_MODE: assert property ((!pending_i && dbmode_i) |=> cnt_reg == 8'h00)
    else $error("clear mode kept a count");
  AST_DECREMENT_MODE: assert property (
    (!pending_i && !dbmode_i && step && !restart_i && cnt_reg != 8'h00)
    |=> cnt_reg == $past(cnt_reg) - 8'h01)
    else $error("decrement mode did not count down");
endmodule : orient_debounce

// file: hdl/orientation_detector.sv
`timescale 1ns/10ps
module orientation_detector
  import orient_pkg::*;
#(
  parameter int unsigned STEP_BASE_CYCLES = STEP_BASE_CYCLES_DEFAULT,
  parameter logic [4:0]  TRIP_THRESHOLD   = TRIP_THRESHOLD_DEFAULT,
  parameter logic [2:0]  TRIP_MARGIN      = TRIP_MARGIN_DEFAULT
)(
  input  wire logic                     MCLK_I,
  input  wire logic                     ARST_N_I,
  input  wire logic [7:0]               REG_ADDR_I,
  input  wire logic                     REG_WR_I,
  input  wire logic                     REG_RD_I,
  input  wire logic [7:0]               REG_WDATA_I,
  output logic      [7:0]               REG_RDATA_O,
  input  wire logic                     SAMPLE_VALID_I,
  input  wire logic signed [AXIS_W-1:0] ACCEL_X_I,
  input  wire logic signed [AXIS_W-1:0] ACCEL_Y_I,
  input  wire logic signed [AXIS_W-1:0] ACCEL_Z_I,
  input  wire logic [2:0]               OUTPUT_SAMPLE_RATE_I,
  input  wire logic [1:0]               OSMODE_SEL_I,
  input  wire logic                     ACTIVE_I,
  input  wire logic                     SLEEP_I,
  output logic                          ORIENT_CHANGED_O
);
  // Trip threshold plus margin must stay inside the usable range
  if (int'(TRIP_THRESHOLD) + int'(TRIP_MARGIN) == 0 ||
      int'(TRIP_THRESHOLD) + int'(TRIP_MARGIN) >= TRIP_SUM_LIMIT) begin : g_bad_trip
    $error("trip threshold plus margin out of range");
  end

  orient_if cand ();

  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] count_reg, count_next;
  logic [7:0] bfz_reg, bfz_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] status_val;
  logic [1:0] code_reg, code_next;
  logic       face_reg, face_next;
  logic       lock_reg, lock_next;
  logic       changed_reg, changed_next;
  logic       first_reg, first_next;
  logic       active_d_reg, sleep_d_reg;
  logic       rd_status, chg_set, pending, commit, first_hit;
  logic       restart, det_en;
  logic [7:0] step_mult;
  logic [3:0] field_bits, cand_bits;

  // Candidate attitude, refreshed once per output sample
  orient_classifier #(
    .TRIP_THRESHOLD (TRIP_THRESHOLD),
    .TRIP_MARGIN    (TRIP_MARGIN)
  ) u_classifier (
    .clk_i      (MCLK_I),
    .rst_n_i    (ARST_N_I),
    .sample_i   (SAMPLE_VALID_I),
    .x_i        (ACCEL_X_I),
    .y_i        (ACCEL_Y_I),
    .z_i        (ACCEL_Z_I),
    .bf_sel_i   (bfz_reg[BFZ_BF_LSB +: 2]),
    .zl_sel_i   (bfz_reg[BFZ_ZL_LSB +: 3]),
    .cur_code_i (code_reg),
    .cur_face_i (face_reg),
    .res        (cand.src)
  );

  // Debounce time step from rate and oversampling mode
  assign step_mult = STEP_MULT[OSMODE_SEL_I][OUTPUT_SAMPLE_RATE_I];

  orient_debounce #(
    .STEP_BASE_CYCLES (STEP_BASE_CYCLES)
  ) u_debounce (
    .clk_i       (MCLK_I),
    .rst_n_i     (ARST_N_I),
    .restart_i   (restart),
    .pending_i   (pending),
    .dbmode_i    (cfg_reg[CFG_DBMODE_BIT]),
    .step_mult_i (step_mult),
    .dbval_i     (count_reg),
    .commit_o    (commit)
  );

  // Status byte as software sees it; bit 4 always reads one
  always_comb begin
    status_val                    = 8'h00;
    status_val[ST_CHANGED_BIT]    = changed_reg;
    status_val[ST_LOCK_BIT]       = lock_reg;
    status_val[ST_FIXED_BIT]      = 1'b1;
    status_val[ST_CODE_LSB +: 2]  = code_reg;
    status_val[ST_FACE_BIT]       = face_reg;
  end

  // Register writes and read data
  always_comb begin
    cfg_next   = cfg_reg;
    count_next = count_reg;
    bfz_next   = bfz_reg;
    rdata_next = rdata_reg;
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        CONFIG_ADDR: cfg_next   = REG_WDATA_I & CONFIG_MASK;
        COUNT_ADDR:  count_next = REG_WDATA_I;
        BFZ_ADDR:    bfz_next   = REG_WDATA_I & BFZ_MASK;
        default:     ;
      endcase
    end
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        STATUS_ADDR: rdata_next = status_val;
        CONFIG_ADDR: rdata_next = cfg_reg;
        COUNT_ADDR:  rdata_next = count_reg;
        BFZ_ADDR:    rdata_next = bfz_reg;
        default:     rdata_next = UNMAPPED_DATA;
      endcase
    end
  end

  // Register file
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cfg_reg   <= CONFIG_RESET;
      count_reg <= COUNT_RESET;
      bfz_reg   <= BFZ_RESET;
      rdata_reg <= 8'h00;
    end else begin
      cfg_reg   <= cfg_next;
      count_reg <= count_next;
      bfz_reg   <= bfz_next;
      rdata_reg <= rdata_next;
    end
  end

  // Detection qualifiers
  always_comb begin
    field_bits = {code_reg, face_reg, lock_reg};
    cand_bits  = {cand.code, cand.face, cand.lock};
    rd_status  = REG_RD_I && (REG_ADDR_I == STATUS_ADDR);
    det_en     = cfg_reg[CFG_EN_BIT] && ACTIVE_I;
    restart    = SLEEP_I != sleep_d_reg;
    // Over-g samples neither start nor finish a transition
    first_hit  = det_en && first_reg && cand.valid && !cand.hold;
    pending    = det_en && !first_reg && !cand.hold && (cand_bits != field_bits);
    chg_set    = first_hit || commit;
  end

  // Orientation state; a set in the clearing cycle wins over the read
  always_comb begin
    code_next    = code_reg;
    face_next    = face_reg;
    lock_next    = lock_reg;
    first_next   = first_reg;
    // Fields follow the candidate whatever the flag holds
    if (chg_set) begin
      code_next = cand.code;
      face_next = cand.face;
      lock_next = cand.lock;
    end
    changed_next = chg_set || (changed_reg && !rd_status);
    if (ACTIVE_I && !active_d_reg) begin
      first_next = 1'b1;
    end else if (first_hit) begin
      first_next = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      code_reg     <= 2'h0;
      face_reg     <= 1'b0;
      lock_reg     <= 1'b0;
      changed_reg  <= 1'b0;
      first_reg    <= 1'b0;
      active_d_reg <= 1'b0;
      sleep_d_reg  <= 1'b0;
    end else begin
      code_reg     <= code_next;
      face_reg     <= face_next;
      lock_reg     <= lock_next;
      changed_reg  <= changed_next;
      first_reg    <= first_next;
      active_d_reg <= ACTIVE_I;
      sleep_d_reg  <= SLEEP_I;
    end
  end

  assign REG_RDATA_O      = rdata_reg;
  assign ORIENT_CHANGED_O = changed_reg;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence seq_bfz_write;
    REG_WR_I && REG_ADDR_I == BFZ_ADDR;
  endsequence

  sequence seq_bfz_read;
    REG_RD_I && !REG_WR_I && REG_ADDR_I == BFZ_ADDR;
  endsequence

  sequence seq_activation;
    ACTIVE_I && !active_d_reg;
  endsequence

  AST_READ_CLEARS: assert property ((rd_status && !chg_set) |=> !ORIENT_CHANGED_O)
    else $error("status read left change flag set");
  AST_SET_WINS: assert property ((rd_status && chg_set) |=> ORIENT_CHANGED_O)
    else $error("change lost against status read");
  AST_FIELD_CHANGE_FLAGS: assert property (!$stable(field_bits) |-> changed_reg)
    else $error("field change without change flag");
  AST_FLAG_NO_FREEZE: assert property (
    (changed_reg && commit) |=> field_bits == $past(cand_bits))
    else $error("fields frozen by change flag");
  AST_OVER_G_FREEZE: assert property (cand.hold |=> $stable(field_bits))
    else $error("orientation moved during over-g");
  AST_DISABLED_FREEZE: assert property (!cfg_reg[CFG_EN_BIT] |=> $stable(field_bits))
    else $error("orientation moved while disabled");
  AST_STATUS_LAYOUT: assert property (
    rd_status |=> REG_RDATA_O[ST_CODE_LSB +: 2] == $past(code_reg) &&
                  REG_RDATA_O[ST_FACE_BIT] == $past(face_reg) &&
                  REG_RDATA_O[ST_LOCK_BIT] == $past(lock_reg) &&
                  REG_RDATA_O[ST_FIXED_BIT])
    else $error("status byte layout wrong");
  AST_BFZ_READBACK: assert property (
    (seq_bfz_write ##1 !REG_WR_I ##1 seq_bfz_read) |=> REG_RDATA_O == ($past(REG_WDATA_I, 3) & BFZ_MASK))
    else $error("angle config read back wrong");
  AST_FIRST_DETECT: assert property (
    (seq_activation ##2 (first_reg && det_en && cand.valid && !cand.hold))
    |=> changed_reg && !first_reg)
    else $error("first detection after activation not flagged");
  AST_UNMAPPED_ZERO: assert property (
    (REG_RD_I && REG_ADDR_I > BFZ_ADDR) |=> REG_RDATA_O == UNMAPPED_DATA)
    else $error("unmapped read not zero");
  AST_RESET_FIELDS: assert property ($rose(ARST_N_I) |-> field_bits == 4'h0)
    else $error("fields not zero after reset");
endmodule : orientation_detector

// file: shared/orient_if.sv
`timescale 1ns/10ps
interface orient_if;
  logic [1:0] code;
  logic       face;
  logic       lock;
  logic       hold;
  logic       valid;
  modport src (output code, face, lock, hold, valid);
  modport dst (input code, face, lock, hold, valid);
endinterface : orient_if

// file: shared/orient_pkg.sv
// Operation
// - Status read clears pending orientation event
// - Bit 7 flags any orientation field change
// - Bit 6 shows z-tilt lockout detected
// - Bits 2:1 encode up, down, right, left
// - Bit 0 reads front 0, back 1
// - Orientation fields reset to zero
// - Flag set on first detection, then changes
// - Every status read clears change flag; a set in the same cycle wins over the read
// - Fields keep updating while flag set
// - Hold orientation when axis exceeds 1.25 g
// - Debounce mode decrements or clears counter
// - Config bit 6 enables detection
// - Debounce count register sets required steps
// - Wake/sleep change resets debounce counter
// - Time step follows rate and oversampling mode
// - Z-lock field selects lockout angle
// - Back/front field selects trip angle, default 75
// - Back/front regions follow selected angle
// - Trip threshold, margin defaults and sum bounds
package orient_pkg;
  // Register map
  localparam logic [7:0] STATUS_ADDR   = 8'h10;
  localparam logic [7:0] CONFIG_ADDR   = 8'h11;
  localparam logic [7:0] COUNT_ADDR    = 8'h12;
  localparam logic [7:0] BFZ_ADDR      = 8'h13;
  localparam logic [7:0] CONFIG_RESET  = 8'h80;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] BFZ_RESET     = 8'h44;
  localparam logic [7:0] CONFIG_MASK   = 8'hC0;
  localparam logic [7:0] BFZ_MASK      = 8'hC7;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // Field positions
  localparam int ST_CHANGED_BIT = 7;
  localparam int ST_LOCK_BIT    = 6;
  localparam int ST_FIXED_BIT   = 4;
  localparam int ST_CODE_LSB    = 1;
  localparam int ST_FACE_BIT    = 0;
  localparam int CFG_DBMODE_BIT = 7;
  localparam int CFG_EN_BIT     = 6;
  localparam int BFZ_BF_LSB     = 6;
  localparam int BFZ_ZL_LSB     = 0;
  // Orientation encodings
  typedef enum logic [1:0] {
    PORTRAIT_UP     = 2'h0,
    PORTRAIT_DOWN   = 2'h1,
    LANDSCAPE_RIGHT = 2'h2,
    LANDSCAPE_LEFT  = 2'h3
  } orient_code_t;
  localparam logic FACE_FRONT = 1'b0;
  localparam logic FACE_BACK  = 1'b1;
  // Acceleration scale at 2 g full range
  localparam int          AXIS_W        = 14;
  localparam int          ONE_G_COUNTS  = 4096;
  localparam logic [13:0] OVER_G_COUNTS = 14'(ONE_G_COUNTS * 5 / 4);
  // Debounce base step of 1.25 ms
  localparam int CLK_PERIOD_NS            = 4;
  localparam int STEP_BASE_NS             = 1250000;
  localparam int STEP_BASE_CYCLES_DEFAULT = STEP_BASE_NS / CLK_PERIOD_NS;
  // Time step in base steps, [oversampling mode][rate code]
  localparam logic [7:0] STEP_MULT [4][8] = '{
    '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h10, 8'h10, 8'h10},
    '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h40, 8'h40},
    '{8'h01, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02},
    '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80, 8'h80}};
  // Tangents scaled by 64
  localparam logic [9:0] Z_TILT_ANGLE_SEL_TAN [8] = '{10'h010, 10'h015, 10'h019, 10'h01E,
                                           10'h023, 10'h02A, 10'h030, 10'h03A};
  localparam logic [9:0] BF_TAN [4] = '{10'h16B, 10'h0EF, 10'h0B0, 10'h089};
  localparam logic [9:0] TAN64_5DEG [18] = '{
    10'h000, 10'h006, 10'h00B, 10'h011, 10'h017, 10'h01E, 10'h025, 10'h02D, 10'h036,
    10'h040, 10'h04C, 10'h05B, 10'h06F, 10'h089, 10'h0B0, 10'h0EF, 10'h16B, 10'h2DC};
  // Trip threshold and margin
  localparam int         MARGIN_DEG [8] = '{0, 4, 7, 11, 14, 17, 21, 24};
  localparam logic [4:0] TRIP_THRESHOLD_DEFAULT = 5'h10;
  localparam logic [2:0] TRIP_MARGIN_DEFAULT    = 3'h4;
  localparam int         THRESHOLD_DEG_NUM      = 45;
  localparam int         THRESHOLD_DEG_DEN      = 16;
  localparam int         TRIP_SUM_LIMIT         = 32;
endpackage : orient_pkg

// file: tb/host_model.sv
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o
);
  // Idle bus at time zero
  initial begin
    addr_o  = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // One-cycle write strobe; stale data is inverted so it is never reused by luck
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask : write_reg

  // Read data is registered, valid one cycle after the strobe edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    #1;
    d = rdata_i;
  endtask : read_reg
endmodule : host_model

// file: tb/test_orientation_detector.sv
`timescale 1ns/10ps
module test_orientation_detector;
  import orient_pkg::*;
  logic              clk;
  logic              rst_n;
  logic [7:0]        addr;
  logic              wr;
  logic              rd;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic              sv;
  logic signed [13:0] ax;
  logic signed [13:0] ay;
  logic signed [13:0] az;
  logic [2:0]        rate;
  logic [1:0]        osm;
  logic              active;
  logic              sleep;
  logic              chg;
  logic [7:0]        d;
  int fail_count = 0;
  int num_checks = 0;
  int m_code = 0;
  int m_face = 0;
  int m_lock = 0;
  int m_flag = 0;
  int m_first = 0;
  int m_en = 1;
  int r;
  int tx [4] = '{0, 0, 1, -1};
  int ty [4] = '{1, -1, 0, 0};

  orientation_detector #(.STEP_BASE_CYCLES(4)) DUT (
    .MCLK_I(clk), .ARST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SAMPLE_VALID_I(sv), .ACCEL_X_I(ax),
    .ACCEL_Y_I(ay), .ACCEL_Z_I(az), .OUTPUT_SAMPLE_RATE_I(rate), .OSMODE_SEL_I(osm),
    .ACTIVE_I(active), .SLEEP_I(sleep), .ORIENT_CHANGED_O(chg));

  host_model hm (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic int iabs(input int v);
    return (v < 0) ? -v : v;
  endfunction : iabs

  task automatic drive_sample(input int x, input int y, input int z);
    @(posedge clk);
    ax <= 14'(x);
    ay <= 14'(y);
    az <= 14'(z);
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
  endtask : drive_sample

  // Reference classifier, exact only for axis-aligned stimulus
  task automatic model_sample(input int x, input int y, input int z);
    int mx;
    int lk;
    int fc;
    int cd;
    mx = (iabs(x) > iabs(y)) ? iabs(x) : iabs(y);
    if (m_en == 0 || iabs(x) > 5120 || iabs(y) > 5120 || iabs(z) > 5120) return;
    lk = (z != 0 && 2 * mx < iabs(z)) ? 1 : 0;
    fc = m_face;
    if (z != 0 && 4 * mx < iabs(z)) fc = (z > 0) ? 1 : 0;
    cd = m_code;
    if (lk == 0) cd = (iabs(x) > iabs(y)) ? ((x >= 0) ? 2 : 3) : ((y >= 0) ? 0 : 1);
    if (m_first != 0 || cd != m_code || fc != m_face || lk != m_lock) m_flag = 1;
    m_first = 0;
    m_code = cd;
    m_face = fc;
    m_lock = lk;
  endtask : model_sample

  task automatic apply(input int x, input int y, input int z);
    drive_sample(x, y, z);
    model_sample(x, y, z);
    repeat (3) @(posedge clk);
  endtask : apply

  // Flag pin off the edge, then the whole status byte; the model clears its flag
  task automatic check_status;
    logic [7:0] s;
    #1;
    chk(8'(chg), 8'(m_flag));
    hm.read_reg(STATUS_ADDR, s);
    chk(s, 8'(m_flag * 128 + m_lock * 64 + 16 + m_code * 2 + m_face));
    m_flag = 0;
  endtask : check_status

  // Poll status until the flag shows, then compare the whole byte
  task automatic await_change(input int x, input int y, input int z);
    logic [7:0] s;
    s = 8'h00;
    model_sample(x, y, z);
    for (int i = 0; i < 60 && s[7] !== 1'b1; i++) begin
      hm.read_reg(STATUS_ADDR, s);
    end
    if (s[7] !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: debounced change never committed", $time);
      finish_test();
    end
    chk(s, 8'(128 + m_lock * 64 + 16 + m_code * 2 + m_face));
    m_flag = 0;
  endtask : await_change

  initial begin
    rst_n = 1'b0;
    sv = 1'b0;
    ax = '0;
    ay = '0;
    az = '0;
    rate = 3'h0;
    osm = 2'h0;
    active = 1'b0;
    sleep = 1'b0;
    void'($urandom(84));
    r = 1000 + int'($urandom % 3000);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    hm.read_reg(CONFIG_ADDR, d);
    chk(d, 8'h80);
    hm.read_reg(COUNT_ADDR, d);
    chk(d, 8'h00);
    hm.read_reg(BFZ_ADDR, d);
    chk(d, 8'h44);
    check_status;
    hm.read_reg(8'h20, d);
    chk(d, 8'h00);
    hm.write_reg(BFZ_ADDR, 8'hFF);
    hm.read_reg(BFZ_ADDR, d);
    chk(d, 8'hC7);
    hm.write_reg(BFZ_ADDR, 8'h44);
    hm.write_reg(STATUS_ADDR, 8'hFF);
    check_status;
    hm.write_reg(CONFIG_ADDR, 8'hFF);
    hm.read_reg(CONFIG_ADDR, d);
    chk(d, 8'hC0);
    // First detection after going active flags even an unchanged attitude
    @(posedge clk);
    active <= 1'b1;
    m_first = 1;
    apply(0, r, 0);
    check_status;
    check_status;
    for (int i = 0; i < 4; i++) begin
      apply(tx[i] * r, ty[i] * r, 0);
      check_status;
    end
    apply(r, 0, 0);
    apply(0, -r, 0);
    check_status;
    apply(0, 0, r);
    check_status;
    apply(0, 0, -r);
    check_status;
    apply(0, r, 0);
    check_status;
    apply(0, -6000, 0);
    check_status;
    // Debounced change must not appear at once; decrement mode counts back down
    hm.write_reg(COUNT_ADDR, 8'h03);
    hm.write_reg(CONFIG_ADDR, 8'h40);
    drive_sample(r, 0, 0);
    repeat (3) @(posedge clk);
    check_status;
    drive_sample(0, r, 0);
    repeat (12) @(posedge clk);
    drive_sample(r, 0, 0);
    await_change(r, 0, 0);
    // Slowest low-power step; a sleep change restarts the count
    hm.write_reg(CONFIG_ADDR, 8'hC0);
    osm  <= 2'h3;
    rate <= 3'h6;
    drive_sample(0, r, 0);
    repeat (600) @(posedge clk);
    check_status;
    @(posedge clk);
    sleep <= 1'b1;
    repeat (1500) @(posedge clk);
    check_status;
    await_change(0, r, 0);
    hm.write_reg(CONFIG_ADDR, 8'h80);
    m_en = 0;
    apply(0, -r, 0);
    repeat (40) @(posedge clk);
    check_status;
    finish_test();
  end
endmodule : test_orientation_detector
